// File: hrwc_pkg.sv
/*
 Package for the head read/write mode controller: register map, field
 positions, reset values and timing counts.
 Assumes a 25 MHz system clock.
*/
package hrwc_pkg;
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned HEAD_W        = 3;
   // Register byte addresses (word index times four)
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_STAT       = 4'h4;
   localparam logic [3:0] REG_IRQ        = 4'h8;
   localparam logic [3:0] REG_MASK       = 4'hC;
   // Control fields
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_HEAD_LSB = 4;
   localparam int unsigned CTRL_PULSE    = 8;
   localparam logic [1:0]  MODE_IDLE     = 2'h0;
   localparam logic [1:0]  MODE_READ     = 2'h1;
   localparam logic [1:0]  MODE_WRITE    = 2'h2;
   // Interrupt bit positions
   localparam int unsigned IRQ_UNSAFE    = 0;
   localparam int unsigned IRQ_SAFE      = 1;
   localparam int unsigned IRQ_TIMEOUT   = 2;
   localparam logic [2:0]  IRQ_RST       = 3'h0;
   localparam logic [11:0] CTRL_RST      = 12'h000;
   // Write-unsafe timing, nanoseconds and clock cycles
   localparam int unsigned UNSAFE_MAX_NS = 8000;
   localparam int unsigned SAFE_MAX_NS   = 1000;
   localparam int unsigned UNSAFE_CYC    =
      (UNSAFE_MAX_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned SAFE_CYC      =
      (SAFE_MAX_NS * (CLK_HZ / 1000000) + 999) / 1000;
   // Half period of generated write data, cycles
   localparam int unsigned HALF_CYC      = 2;
   localparam int unsigned CNT_W         = 10;
endpackage

// File: hrwc_ctrl.sv
/*
 Host controller for a multi-channel read/write preamplifier.
 Software sets mode, head and write-data pulses over Avalon-MM; the
 controller drives chip select, read/write, head select and write data
 pins and watches the write-unsafe flag. Assumes rst_n may be async.
*/
// Added by the designer: register access over Avalon-MM and the register offsets.
// Overview of operation
// R1: head select pins carry the head index as a binary number, MSB high.
// R2: chip select low with read/write low requests write mode.
// R3: each falling edge of write data flips device current direction.
// R4: read selection presets direction so next write starts on X side.
// R5: device raises write-unsafe on faults, read, idle or no current.
// R6: two write-data falling edges after the fault clear the flag.
// R7: device blocks write current during supply faults in any mode.
// R8: chip select low with read/write high requests read mode.
// R9: device gates off write current in read mode.
// R10: chip select high means idle whatever read/write shows.
// R11: only one device may be selected at a time on shared lines.
// R12: inputs pull up, an open line cannot produce writing.
// R13: unsafe asserts within 1.6 to 8.0 us, clears within 1.0 us.
// R14: mode and head decoding are combinational; other heads stay idle.
`timescale 1ns/1ns
module hrwc_ctrl
   import hrwc_pkg::*;
#(
   parameter int unsigned EDGE_COUNT = 2
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             chip_sel_n,
   output logic             read_write,
   output logic [2:0]       head_index_sel,
   output logic             write_data_input,
   input  wire logic        write_unsafe,
   output logic             irq
);
   typedef enum logic [1:0] {S_IDLE, S_HIGH, S_LOW} hrwc_wd_t;

   logic          rs1_q, rs2_q, rst_i;
   logic          wu1_q, wu2_q, wu_prev_q;
   logic [1:0]    mode_q, mode_d;
   logic [2:0]    head_q, head_d;
   logic [3:0]    pend_q, pend_d;
   hrwc_wd_t      wd_q, wd_d;
   logic [CNT_W-1:0] hc_q, hc_d, wt_q, wt_d;
   logic [2:0]    ist_q, ist_d, msk_q, msk_d;
   logic          cs_q, cs_d, rw_q, rw_d, wdo_q, wdo_d;
   logic          ack_q, ack_d, irq_d;
   logic [31:0]   rd_q, rd_d;

   // Reset release and pin synchronisers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end
      else
      begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   assign rst_i = rs2_q;

   always_ff @(posedge clk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         wu1_q     <= 1'b1;
         wu2_q     <= 1'b1;
         wu_prev_q <= 1'b1;
      end
      else
      begin
         wu1_q     <= write_unsafe;
         wu2_q     <= wu1_q;
         wu_prev_q <= wu2_q;
      end
   end

   always_comb
   begin
      mode_d = mode_q;
      head_d = head_q;
      pend_d = pend_q;
      wd_d   = wd_q;
      hc_d   = hc_q;
      wt_d   = wt_q;
      ist_d  = ist_q;
      msk_d  = msk_q;
      ack_d  = 1'b0;
      rd_d   = rd_q;
      // Bus slave: every access answers one cycle after it is seen
      if ((avs_read || avs_write) && !ack_q)
      begin
         ack_d = 1'b1;
         rd_d  = 32'h0000_0000;
         if (avs_address == REG_CTRL)
         begin
            if (avs_write)
            begin
               mode_d = avs_writedata[CTRL_MODE_LSB +: 2];
               head_d = avs_writedata[CTRL_HEAD_LSB +: HEAD_W];
               pend_d = avs_writedata[CTRL_PULSE +: 4];
            end
            rd_d = {20'h0_0000, pend_q, 1'b0, head_q, 2'h0, mode_q};
         end
         else if (avs_address == REG_STAT)
            rd_d = {30'h0000_0000, wd_q != S_IDLE, wu2_q};
         else if (avs_address == REG_IRQ)
         begin
            if (avs_write)
               ist_d = ist_q & ~avs_writedata[2:0];
            rd_d = {29'h0000_0000, ist_q};
         end
         else if (avs_address == REG_MASK)
         begin
            if (avs_write)
               msk_d = avs_writedata[2:0];
            rd_d = {29'h0000_0000, msk_q};
         end
      end
      // Write data pulse generator, starts pulses only in write mode
      case (wd_q)
         S_IDLE:
            if (pend_q != 4'h0 && mode_q == MODE_WRITE)
            begin
               wd_d = S_HIGH;
               hc_d = '0;
            end
         S_HIGH:
            if (hc_q == CNT_W'(HALF_CYC - 1))
            begin
               wd_d = S_LOW; // see R3, R6
               hc_d = '0;
            end
            else
               hc_d = hc_q + 1'b1;
         S_LOW:
            if (hc_q == CNT_W'(HALF_CYC - 1))
            begin
               wd_d = S_IDLE;
               pend_d = pend_d - 4'h1;
            end
            else
               hc_d = hc_q + 1'b1;
         default:
            wd_d = S_IDLE;
      endcase
      // Flag transitions and a watchdog on the safe-going response
      if (wt_q != '0)
         wt_d = wt_q - 1'b1;
      if (mode_q == MODE_WRITE && wd_q == S_LOW && wt_q == '0 && wu2_q)
         wt_d = CNT_W'(UNSAFE_CYC + SAFE_CYC); // see R13
      if (wu2_q && !wu_prev_q)
         ist_d[IRQ_UNSAFE] = 1'b1; // see R5
      if (!wu2_q && wu_prev_q)
      begin
         ist_d[IRQ_SAFE] = 1'b1; // see R6
         wt_d = '0;
      end
      if (wt_q == CNT_W'(1) && wu2_q)
         ist_d[IRQ_TIMEOUT] = 1'b1;
   end

   // Pins decoded from the latched mode, pulse state and interrupt bits
   always_comb
   begin
      cs_d  = (mode_q == MODE_IDLE) || (mode_q == 2'h3); // see R10, R11
      rw_d  = (mode_q != MODE_WRITE); // see R2, R8, R12
      wdo_d = (wd_q == S_HIGH) || (wd_q == S_IDLE);
      irq_d = |(ist_q & msk_q);
   end

   always_ff @(posedge clk or negedge rst_i)
   begin
      if (!rst_i)
      begin
         mode_q <= CTRL_RST[1:0];
         head_q <= CTRL_RST[6:4];
         pend_q <= CTRL_RST[11:8];
         wd_q   <= S_IDLE;
         hc_q   <= '0;
         wt_q   <= '0;
         ist_q  <= IRQ_RST;
         msk_q  <= IRQ_RST;
         ack_q  <= 1'b0;
         rd_q   <= 32'h0000_0000;
         chip_sel_n       <= 1'b1;
         read_write       <= 1'b1;
         head_index_sel   <= 3'h0;
         write_data_input <= 1'b1;
         irq              <= 1'b0;
         avs_readdata     <= 32'h0000_0000;
         avs_waitrequest  <= 1'b1;
      end
      else
      begin
         mode_q <= mode_d;
         head_q <= head_d;
         pend_q <= pend_d;
         wd_q   <= wd_d;
         hc_q   <= hc_d;
         wt_q   <= wt_d;
         ist_q  <= ist_d;
         msk_q  <= msk_d;
         ack_q  <= ack_d;
         rd_q   <= rd_d;
         chip_sel_n       <= cs_d;
         read_write       <= rw_d;
         head_index_sel   <= head_q; // see R1, R14
         write_data_input <= wdo_d;
         irq              <= irq_d;
         avs_readdata     <= rd_d;
         avs_waitrequest  <= !ack_d;
      end
   end

   property p_idle_pins;
      @(posedge clk) disable iff (!rst_i)
      (mode_q == MODE_IDLE) |=> chip_sel_n;
   endproperty
   a_idle_pins: assert property (p_idle_pins) // see R10
      else $error("idle mode left chip select low");

   property p_write_pins;
      @(posedge clk) disable iff (!rst_i)
      (mode_q == MODE_WRITE) |=> (!chip_sel_n && !read_write);
   endproperty
   a_write_pins: assert property (p_write_pins) // see R2
      else $error("write mode pins wrong");

   property p_read_pins;
      @(posedge clk) disable iff (!rst_i)
      (mode_q == MODE_READ) |=> (!chip_sel_n && read_write);
   endproperty
   a_read_pins: assert property (p_read_pins) // see R8
      else $error("read mode pins wrong");

   property p_head;
      @(posedge clk) disable iff (!rst_i)
      $changed(head_q) |=> (head_index_sel == $past(head_q));
   endproperty
   a_head: assert property (p_head) // see R1
      else $error("head select not following index");

   property p_fall;
      @(posedge clk) disable iff (!rst_i)
      $fell(write_data_input) |-> $past(mode_q, 2) == MODE_WRITE;
   endproperty
   a_fall: assert property (p_fall) // see R3
      else $error("write data fell outside write mode");

   property p_pulse_len;
      @(posedge clk) disable iff (!rst_i)
      $fell(write_data_input) |-> !write_data_input [*2] ##1 write_data_input;
   endproperty
   a_pulse_len: assert property (p_pulse_len) // see R6
      else $error("write data low pulse width wrong");

   property p_irq;
      @(posedge clk) disable iff (!rst_i)
      (wu2_q && !wu_prev_q && msk_q[IRQ_UNSAFE]) ##1 msk_q[IRQ_UNSAFE]
         |=> irq;
   endproperty
   a_irq: assert property (p_irq) // see R5
      else $error("interrupt not raised");

   property p_noread_write;
      @(posedge clk) disable iff (!rst_i)
      read_write |-> write_data_input || $past(mode_q, 2) == MODE_WRITE
         || $past(mode_q) == MODE_WRITE;
   endproperty
   a_noread_write: assert property (p_noread_write) // see R12
      else $error("write data pulsed with read/write high");

   c_write: cover property (@(posedge clk) !chip_sel_n && !read_write);
   c_read: cover property (@(posedge clk) !chip_sel_n && read_write);
   c_safe: cover property (@(posedge clk) ist_q[IRQ_SAFE]);
   c_clear: cover property (@(posedge clk)
      mode_q == MODE_WRITE && pend_q == 4'(EDGE_COUNT));
endmodule

// File: hrwc_dev_model.sv
/*
 Behavioural model of the preamplifier's digital side: mode and head
 decode, write direction flip-flop and write-unsafe flag.
 Assumes the controller's registered pins and the bench clock.
*/
`timescale 1ns/1ns
module hrwc_dev_model
#(
   parameter int UNSAFE_DLY = 50
)
(
   input  wire logic       clk,
   input  wire logic       chip_sel_n,
   input  wire logic       read_write,
   input  wire logic [2:0] head_index_sel,
   input  wire logic       write_data_input,
   input  wire logic       head_open,
   input  wire logic       supply_fault,
   output logic            write_unsafe,
   output logic            write_dir,
   output logic [7:0]      head_active
);
   logic       wr;
   logic       rd;
   logic       fell;
   logic       wdi_q = 1'b1;
   logic [1:0] falls = 2'h0;
   int         dly   = 0;
   assign wr = !chip_sel_n && !read_write;
   assign rd = !chip_sel_n && read_write;
   assign fell = wdi_q && !write_data_input;
   // Only the decoded head is active, none when idle
   assign head_active = (wr || rd) ? 8'h01 << head_index_sel : 8'h00;
   initial write_unsafe = 1'b1;
   initial write_dir = 1'b0;
   always @(posedge clk)
   begin
      wdi_q <= write_data_input;
      if (rd)
         write_dir <= 1'b0;
      else if (wr && fell)
         write_dir <= !write_dir;
      if (!wr || head_open || supply_fault)
      begin
         falls <= 2'h0;
         // Flag is open collector: high also when released
         if (dly == UNSAFE_DLY)
            write_unsafe <= 1'b1;
         else
            dly <= dly + 1;
      end
      else
      begin
         dly <= 0;
         if (write_unsafe && fell)
            falls <= falls + 2'h1;
         if (write_unsafe && fell && falls == 2'h1)
            write_unsafe <= 1'b0;
      end
   end
endmodule

// File: tb.sv
/*
 Self-checking bench for the read/write mode controller.
 Assumes the device model stands on the pin side.
*/
`timescale 1ns/1ns
module tb;
   import hrwc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        chip_sel_n;
   logic        read_write;
   logic [2:0]  head_index_sel;
   logic        write_data_input;
   logic        write_unsafe;
   logic        irq;
   logic        head_open = 1'b0;
   logic        supply_fault = 1'b0;
   logic        write_dir;
   logic [7:0]  head_active;
   logic [31:0] q;
   int          n_errors = 0;
   int          compares = 0;
   int          cyc = 0;
   always #20 clk = !clk;
   hrwc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .chip_sel_n(chip_sel_n),
      .read_write(read_write), .head_index_sel(head_index_sel),
      .write_data_input(write_data_input), .write_unsafe(write_unsafe),
      .irq(irq));
   hrwc_dev_model i_dev (.clk(clk), .chip_sel_n(chip_sel_n),
      .read_write(read_write), .head_index_sel(head_index_sel),
      .write_data_input(write_data_input), .head_open(head_open),
      .supply_fault(supply_fault),
      .write_unsafe(write_unsafe), .write_dir(write_dir),
      .head_active(head_active));
   task conclude;
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50)
         chk(32'h1, 32'h0);
   endtask
   task settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task wait_idle;
      settle(3);
      q = 32'h0000_0F00;
      for (int i = 0; i < 40 && q[11:8] !== 4'h0; i++)
         bus(1'b0, REG_CTRL, 32'h0);
      chk({28'h0, q[11:8]}, 32'h0);
      bus(1'b0, REG_STAT, 32'h0);
      chk({31'h0, q[1]}, 32'h0);
      settle(4);
   endtask
   task t_reset;
      chk({chip_sel_n, read_write, head_index_sel, write_data_input, irq},
         {1'b1, 1'b1, 3'h0, 1'b1, 1'b0});
      bus(1'b0, REG_CTRL, 32'h0);
      chk(q, {20'h0, CTRL_RST});
      bus(1'b0, REG_IRQ, 32'h0);
      chk(q, {29'h0, IRQ_RST});
      bus(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
   endtask
   task t_heads;
      for (int h = 0; h < 8; h++)
      begin
         bus(1'b1, REG_CTRL, (h << CTRL_HEAD_LSB) | MODE_READ);
         settle(2);
         chk({chip_sel_n, read_write, head_index_sel}, {2'b01, 3'(h)});
         chk(head_active, 8'h01 << h);
         chk(write_dir, 1'b0);
      end
      bus(1'b1, REG_CTRL, 32'h53);
      settle(2);
      chk({chip_sel_n, head_active}, {1'b1, 8'h00});
   endtask
   task t_write(input int h, input int n, input logic dir);
      bus(1'b1, REG_CTRL, (n << CTRL_PULSE) | (h << CTRL_HEAD_LSB) | MODE_WRITE);
      wait_idle;
      chk({chip_sel_n, read_write, head_active}, {2'b00, 8'h01 << h});
      chk(write_dir, dir);
      chk(write_unsafe, 1'b0);
      bus(1'b0, REG_STAT, 32'h0);
      chk(q[0], 1'b0);
   endtask
   task t_irq;
      chk(irq, 1'b0);
      bus(1'b1, REG_MASK, 32'h2);
      settle(2);
      chk(irq, 1'b1);
      bus(1'b1, REG_IRQ, 32'h2);
      settle(2);
      chk(irq, 1'b0);
   endtask
   // Open head or supply fault, then recovery by two write pulses
   task t_fault(input logic sup);
      bus(1'b1, REG_IRQ, 32'h7);
      bus(1'b1, REG_MASK, 32'h1);
      head_open <= !sup;
      supply_fault <= sup;
      settle(60);
      chk({write_unsafe, irq}, 2'b11);
      head_open <= 1'b0;
      supply_fault <= 1'b0;
      t_write(2, 2, 1'b1);
      bus(1'b1, REG_IRQ, 32'h1);
      settle(2);
      chk(irq, 1'b0);
   endtask
   // One pulse only after a read: flag stays up, watchdog must fire
   task t_timeout;
      bus(1'b1, REG_CTRL, 32'h21);
      settle(80);
      bus(1'b1, REG_IRQ, 32'h7);
      bus(1'b1, REG_CTRL, 32'h122);
      settle(240);
      chk(write_dir, 1'b1);
      bus(1'b0, REG_IRQ, 32'h0);
      chk(q, 32'h4);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         conclude;
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_heads;
      bus(1'b1, REG_CTRL, 32'h51);
      t_write(5, 3, 1'b1);
      t_irq;
      t_write(7, 2, 1'b1);
      t_fault(1'b0);
      t_fault(1'b1);
      t_timeout;
      conclude;
   end
endmodule
